// ---- logic/dr3_params.svh ----
// How it works
// (R01) Data bus is four or eight bits
// (R02) Device drives strobe edge-aligned on reads
// (R03) Controller drives strobe centred on writes
// (R04) Termination strobe enabled disables write masking
// (R05) Spare balls unused narrow, used when wide
// (R06) Two ranks of eight banks each
// (R07) Two data words per clock cycle
// (R08) One eight-word core transfer per access
// (R09) Bursts follow programmed length and order
// (R10) Controller activates a row before access
// (R11) Activate opens the addressed bank row
// (R12) Column command selects rank, bank, column
// (R13) Rank ignores commands while select high
// (R14) Pins sampled on command clock rising edge
// (R15) Chop bit low gives four-word burst
// (R16) Masked write words are not stored
// (R17) Ranks keep own enable, termination, banks
`ifndef DR3_PARAMS_SVH
`define DR3_PARAMS_SVH

// read and write latency in link cycles
`define DR3_RD_LAT          4'h5
`define DR3_WR_LAT          4'h4
// address bit positions
`define DR3_CHOP_SELECT_BIT 12
`define DR3_AP_BIT          10
// strobe level per half cycle, bit 0 is the first half
`define DR3_DQS_RD          2'h1
`define DR3_DQS_WR          2'h2
// buffering and core size
`define DR3_FIFO_DEPTH      8
`define DR3_CORE_WORDS      8192

`endif

// ---- logic/dr3_pkg.sv ----
package dr3_pkg;

  typedef enum logic [1:0] {DR3_BL8, DR3_BC4, DR3_OTF} dr3_bl_e;
  typedef enum logic [1:0] {DR3_IDLE, DR3_WAIT, DR3_BURST} dr3_st_e;

  typedef struct packed {
    logic [1:0]  cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [14:0] addr;
    logic [1:0]  cke;
    logic [1:0]  odt;
  } dr3_cmd_s;

  typedef struct packed {
    logic [15:0] dq;
    logic [1:0]  write_mask;
    logic [1:0]  dqs;
    logic [1:0]  dqs_c;
  } dr3_din_s;

  typedef struct packed {
    logic [15:0] dq;
    logic [7:0]  dq_oe;
    logic [1:0]  dqs;
    logic [1:0]  dqs_c;
    logic        dqs_oe;
    logic        term_strobe_true;
    logic        term_strobe_comp;
  } dr3_dout_s;

  typedef struct packed {
    logic    wide;
    logic    term_en;
    dr3_bl_e burst_length;
    logic    interleave;
  } dr3_cfg_s;

  typedef struct packed {
    logic [1:0] rank_open;
    logic       rd_busy;
    logic       wr_busy;
    logic       err;
    logic       ovf;
  } dr3_stat_s;

  typedef struct packed {
    logic [12:0] idx;
    logic [63:0] data;
    logic [7:0]  mask;
  } dr3_wr_s;

endpackage

// ---- logic/dr3_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module dr3_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] hold;
  } dr3_sync_s;

  dr3_sync_s st;
  dr3_sync_s next_st;

  always_comb begin
    next_st.meta = d;
    next_st.hold = st.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.hold;
endmodule

`default_nettype wire

// ---- logic/dr3_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module dr3_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   count;
  } dr3_fifo_s;

  dr3_fifo_s    st;
  dr3_fifo_s    next_st;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  assign in_ready  = st.count != (AW+1)'(DEPTH);
  assign out_valid = st.count != '0;
  assign out_data  = mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wp] <= in_data;
    end
  end

  fill_count_a: assert property (@(posedge clk) disable iff (rst)
    push && !pop |=> st.count == $past(st.count) + 1'b1 && out_valid)
    else $error("fifo count did not grow on a lone push");
endmodule

`default_nettype wire

// ---- logic/dr3_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dr3_params.svh"

module dr3_dev (
  // system clock, reset and configuration
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire dr3_pkg::dr3_cfg_s  cfg,
  // status toward the system clock
  output var  dr3_pkg::dr3_stat_s status,
  // link clock and command pins
  input  wire logic               cmd_clock_true,
  input  wire dr3_pkg::dr3_cmd_s  cmd,
  // data, mask and strobe pins
  input  wire dr3_pkg::dr3_din_s  din,
  output var  dr3_pkg::dr3_dout_s dout
);
  import dr3_pkg::*;

  localparam int RD_FIRST = int'(`DR3_RD_LAT) + 1;

  // ==========================================================
  // helpers
  // ==========================================================
  // nibble-wrapped sequential order, or xor interleave
  function automatic logic [2:0] burst_pos(input logic [2:0] start,
                                           input logic [2:0] i,
                                           input logic       inter);
    burst_pos = inter ? (start ^ i) :
                {start[2] ^ i[2], start[1:0] + i[1:0]};
  endfunction
  // core word index: rank, bank, low row bits, column group
  function automatic logic [12:0] core_idx(input logic        rank,
                                           input logic [2:0]  ba,
                                           input logic [14:0] row,
                                           input logic [14:0] col);
    core_idx = {rank, ba, row[1:0], col[9:3]};
  endfunction
  function automatic logic chop_of(input dr3_bl_e   bl,
                                   input logic [14:0] addr);
    chop_of = (bl == DR3_BC4) ||
              (bl == DR3_OTF && !addr[`DR3_CHOP_SELECT_BIT]);
  endfunction

  // ==========================================================
  // link state
  // ==========================================================
  typedef struct packed {
    dr3_cmd_s              cmd;
    dr3_din_s              din;
    logic [1:0][7:0]       open;
    logic [1:0][7:0][14:0] row;
    dr3_st_e               rd_st;
    logic [3:0]            rd_cnt;
    logic [1:0]            rd_beat;
    logic [2:0]            rd_start;
    logic                  chopped_burst;
    dr3_st_e               wr_st;
    logic [3:0]            wr_cnt;
    logic [1:0]            wr_beat;
    logic [2:0]            wr_start;
    logic                  wr_chop;
    logic [12:0]           wr_idx;
    logic [63:0]           wr_data;
    logic [7:0]            wr_mask;
    logic                  wr_push;
    logic                  err;
    logic                  ovf;
    dr3_stat_s             stat;
    dr3_dout_s             out;
  } dr3_link_s;
  dr3_link_s   st;
  dr3_link_s   next_st;
  logic        rst_link;
  dr3_cfg_s    cfg_l;
  logic [1:0]  sel;
  logic        is_act;
  logic        is_rd;
  logic        is_wr;
  logic        is_pre;
  logic        rk;
  logic        col_ok;
  logic        rd_go;
  logic        wr_go;
  logic [12:0] col_idx;
  logic        strobe_ok;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_out_ready;
  dr3_wr_s     f_in;
  dr3_wr_s     f_out;
  logic [63:0] mem [`DR3_CORE_WORDS];
  logic [63:0] rd_word;

  // ==========================================================
  // crossings
  // ==========================================================
  dr3_sync #(.W(1)) u_rst_sync (
    .clk (cmd_clock_true),
    .rst (1'b0),
    .d   (srst),
    .q   (rst_link)
  );
  // configuration is quasi-static: change it only while idle
  dr3_sync #(.W($bits(dr3_cfg_s))) u_cfg_sync (
    .clk (cmd_clock_true),
    .rst (rst_link),
    .d   (cfg),
    .q   (cfg_l)
  );
  dr3_sync #(.W($bits(dr3_stat_s))) u_stat_sync (
    .clk (clk_sys),
    .rst (srst),
    .d   (st.stat),
    .q   (status)
  );

  // ==========================================================
  // command decode
  // ==========================================================
  assign sel    = ~st.cmd.cs_n & st.cmd.cke;                       // [R13] [R17]
  assign is_act = !st.cmd.ras_n && st.cmd.cas_n && st.cmd.we_n;
  assign is_rd  = st.cmd.ras_n && !st.cmd.cas_n && st.cmd.we_n;
  assign is_wr  = st.cmd.ras_n && !st.cmd.cas_n && !st.cmd.we_n;
  assign is_pre = !st.cmd.ras_n && st.cmd.cas_n && !st.cmd.we_n;
  // lowest selected rank takes a column command
  assign rk      = !sel[0];                                        // [R12]
  assign col_ok  = (|sel) && st.open[rk][st.cmd.ba];               // [R10]
  assign rd_go   = col_ok && is_rd && st.rd_st == DR3_IDLE;
  assign wr_go   = col_ok && is_wr && st.wr_st == DR3_IDLE;
  assign col_idx = core_idx(rk, st.cmd.ba, st.row[rk][st.cmd.ba], st.cmd.addr);  // [R12]
  // write words arrive with a strobe rising mid-cycle
  assign strobe_ok = st.din.dqs == `DR3_DQS_WR && st.din.dqs_c == ~`DR3_DQS_WR;  // [R03]

  // ==========================================================
  // write buffer toward the core
  // ==========================================================
  assign f_in = '{idx: st.wr_idx, data: st.wr_data, mask: st.wr_mask};
  // a read fetch owns the core port, so the drain stalls
  assign f_out_ready = !rd_go;

  dr3_fifo #(.W($bits(dr3_wr_s)), .DEPTH(`DR3_FIFO_DEPTH)) u_wr_fifo (
    .clk       (cmd_clock_true),
    .rst       (rst_link),
    .in_valid  (st.wr_push),
    .in_ready  (f_in_ready),
    .in_data   (f_in),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out)
  );

  // ==========================================================
  // core array: one eight-word transfer per access
  // ==========================================================
  always_ff @(posedge cmd_clock_true) begin
    if (rd_go) begin
      rd_word <= mem[col_idx];                                     // [R08]
    end
    if (f_out_valid && f_out_ready) begin
      for (int k = 0; k < 8; k++) begin
        if (!f_out.mask[k]) begin
          mem[f_out.idx][k*8 +: 8] <= f_out.data[k*8 +: 8];        // [R16]
        end
      end
    end
  end

  // ==========================================================
  // sequencing
  // ==========================================================
  always_comb begin
    logic [2:0] p0;
    logic [2:0] p1;
    logic [7:0] w0;
    logic [7:0] w1;
    logic       use_mask;
    p0       = '0;
    p1       = '0;
    w0       = '0;
    w1       = '0;
    use_mask = !(cfg_l.wide && cfg_l.term_en);                     // [R04]
    next_st  = st;
    next_st.cmd     = cmd;                                         // [R14]
    next_st.din     = din;
    next_st.wr_push = 1'b0;
    // bank state, each rank on its own
    for (int r = 0; r < 2; r++) begin
      if (sel[r] && is_act) begin
        next_st.open[r][st.cmd.ba] = 1'b1;                         // [R06] [R11]
        next_st.row[r][st.cmd.ba]  = st.cmd.addr;                  // [R11]
      end
      if (sel[r] && is_pre) begin
        if (st.cmd.addr[`DR3_AP_BIT]) begin
          next_st.open[r] = '0;
        end else begin
          next_st.open[r][st.cmd.ba] = 1'b0;
        end
      end
    end
    if ((|sel) && (is_rd || is_wr) && !col_ok) begin
      next_st.err = 1'b1;
    end
    // read burst
    case (st.rd_st)
      DR3_IDLE: begin
        if (rd_go) begin
          next_st.rd_st         = DR3_WAIT;
          next_st.rd_cnt        = `DR3_RD_LAT;
          next_st.rd_start      = st.cmd.addr[2:0];                // [R09]
          next_st.chopped_burst = chop_of(cfg_l.burst_length,
                                          st.cmd.addr);            // [R15]
        end
      end
      DR3_WAIT: begin
        if (st.rd_cnt == 4'h1) begin
          next_st.rd_st   = DR3_BURST;
          next_st.rd_beat = 2'h0;
        end else begin
          next_st.rd_cnt = st.rd_cnt - 4'h1;
        end
      end
      DR3_BURST: begin
        if (st.rd_beat == (st.chopped_burst ? 2'h1 : 2'h3)) begin  // [R09] [R15]
          next_st.rd_st = DR3_IDLE;
        end else begin
          next_st.rd_beat = st.rd_beat + 2'h1;
        end
      end
      default: begin
        next_st.rd_st = DR3_IDLE;
      end
    endcase
    // two words leave per cycle while a read burst runs
    next_st.out.dq     = '0;
    next_st.out.dq_oe  = '0;
    next_st.out.dqs    = '0;
    next_st.out.dqs_c  = '0;
    next_st.out.dqs_oe = 1'b0;
    if (next_st.rd_st == DR3_BURST) begin
      p0 = burst_pos(next_st.rd_start, {next_st.rd_beat, 1'b0},
                     cfg_l.interleave);                            // [R09]
      p1 = burst_pos(next_st.rd_start, {next_st.rd_beat, 1'b1},
                     cfg_l.interleave);
      w0 = rd_word[int'(p0)*8 +: 8];
      w1 = rd_word[int'(p1)*8 +: 8];
      if (!cfg_l.wide) begin
        w0[7:4] = 4'h0;                                            // [R05]
        w1[7:4] = 4'h0;
      end
      next_st.out.dq     = {w1, w0};                               // [R07]
      next_st.out.dq_oe  = cfg_l.wide ? 8'hff : 8'h0f;             // [R01] [R05]
      next_st.out.dqs    = `DR3_DQS_RD;                            // [R02]
      next_st.out.dqs_c  = ~`DR3_DQS_RD;
      next_st.out.dqs_oe = 1'b1;
    end
    // write burst capture
    case (st.wr_st)
      DR3_IDLE: begin
        if (wr_go) begin
          next_st.wr_st    = DR3_WAIT;
          next_st.wr_cnt   = `DR3_WR_LAT;
          next_st.wr_start = st.cmd.addr[2:0];
          next_st.wr_chop  = chop_of(cfg_l.burst_length, st.cmd.addr);  // [R15]
          next_st.wr_idx   = col_idx;                              // [R12]
          next_st.wr_data  = '0;
          next_st.wr_mask  = 8'hff;
        end
      end
      DR3_WAIT: begin
        if (st.wr_cnt == 4'h1) begin
          next_st.wr_st   = DR3_BURST;
          next_st.wr_beat = 2'h0;
        end else begin
          next_st.wr_cnt = st.wr_cnt - 4'h1;
        end
      end
      DR3_BURST: begin
        if (strobe_ok) begin
          p0 = burst_pos(st.wr_start, {st.wr_beat, 1'b0}, cfg_l.interleave);  // [R09]
          p1 = burst_pos(st.wr_start, {st.wr_beat, 1'b1}, cfg_l.interleave);
          w0 = st.din.dq[7:0];
          w1 = st.din.dq[15:8];
          if (!cfg_l.wide) begin
            w0[7:4] = 4'h0;                                        // [R01] [R05]
            w1[7:4] = 4'h0;
          end
          next_st.wr_data[int'(p0)*8 +: 8] = w0;                   // [R07]
          next_st.wr_data[int'(p1)*8 +: 8] = w1;
          next_st.wr_mask[p0] = use_mask && st.din.write_mask[0];  // [R16]
          next_st.wr_mask[p1] = use_mask && st.din.write_mask[1];  // [R16]
          if (st.wr_beat == (st.wr_chop ? 2'h1 : 2'h3)) begin
            next_st.wr_st   = DR3_IDLE;
            next_st.wr_push = 1'b1;
          end else begin
            next_st.wr_beat = st.wr_beat + 2'h1;
          end
        end
      end
      default: begin
        next_st.wr_st = DR3_IDLE;
      end
    endcase
    if (st.wr_push && !f_in_ready) begin
      next_st.ovf = 1'b1;
    end
    // termination strobe pair replaces the mask when wide and term_en is set
    next_st.out.term_strobe_true = cfg_l.wide && cfg_l.term_en &&
                                   |(st.cmd.odt & st.cmd.cke);    // [R04] [R17]
    next_st.out.term_strobe_comp = next_st.out.term_strobe_true;   // [R05]
    next_st.stat.rank_open = {|st.open[1], |st.open[0]};
    next_st.stat.rd_busy   = st.rd_st != DR3_IDLE;
    next_st.stat.wr_busy   = st.wr_st != DR3_IDLE;
    next_st.stat.err       = st.err;
    next_st.stat.ovf       = st.ovf;
  end

  always_ff @(posedge cmd_clock_true) begin
    if (rst_link) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.out;

  // ==========================================================
  // checks
  // ==========================================================
  strobe_align_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R02]
    st.out.dqs_oe == (st.rd_st == DR3_BURST) &&
    (!st.out.dqs_oe || (st.out.dqs == `DR3_DQS_RD && st.out.dqs_c == ~`DR3_DQS_RD)))
    else $error("read strobe not aligned with read burst");
  spare_balls_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R05]
    !cfg_l.wide && $stable(cfg_l.wide) |-> st.out.dq_oe[7:4] == 4'h0 && !st.out.term_strobe_comp)
    else $error("spare balls active in narrow mode");
  term_mask_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R04]
    st.out.term_strobe_true |-> $past(cfg_l.wide) && $past(cfg_l.term_en))
    else $error("termination strobe without wide mode and enable");
  cs_ignore_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R13]
    st.cmd.cs_n == 2'h3 |=> $stable(st.open) && $stable(st.row))
    else $error("bank state changed with no rank selected");
  act_open_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R11]
    sel[0] && is_act |=> st.open[0][$past(st.cmd.ba)] &&
    st.row[0][$past(st.cmd.ba)] == $past(st.cmd.addr))
    else $error("activate did not open the addressed row");
  rd_latency_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R08]
    rd_go |-> !st.out.dqs_oe ##RD_FIRST st.out.dqs_oe)
    else $error("read burst not on time");
  burst_len_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R09]
    $rose(st.out.dqs_oe) && !st.chopped_burst |-> st.out.dqs_oe [*4] ##1 !st.out.dqs_oe)
    else $error("full burst not four cycles long");
  chop_len_a: assert property (@(posedge cmd_clock_true) disable iff (rst_link)  // [R15]
    $rose(st.out.dqs_oe) && st.chopped_burst |-> st.out.dqs_oe [*2] ##1 !st.out.dqs_oe)
    else $error("chopped burst not two cycles long");
endmodule

`default_nettype wire

// ---- tb/dr3_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module dr3_ctrl_model (
  // link clock
  input  wire logic              lclk,
  // command and write data toward the device
  output var  dr3_pkg::dr3_cmd_s cmd,
  output var  dr3_pkg::dr3_din_s din
);
  import dr3_pkg::*;

  logic busy;

  initial begin
    busy = 1'b0;
    cmd  = '{cs_n: 2'h3, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 3'h0,
             addr: 15'h0000, cke: 2'h3, odt: 2'h0};
    din  = '{dq: 16'h5a5a, write_mask: 2'h0, dqs: 2'h0, dqs_c: 2'h3};
  end

  // ======
  // released data bus: toggles every cycle so stale data never looks valid
  always @(negedge lclk) begin
    if (!busy) begin
      din.dq         <= ~din.dq;
      din.write_mask <= ~din.write_mask;
      din.dqs        <= 2'h0;
      din.dqs_c      <= 2'h3;
    end
  end

  // ======
  // one command cycle, then deselect
  task automatic issue(input logic [1:0] cs_n, input logic [2:0] op, input logic [2:0] ba, input logic [14:0] a);
    @(negedge lclk);
    cmd.cs_n = cs_n;
    {cmd.ras_n, cmd.cas_n, cmd.we_n} = op;
    cmd.ba   = ba;
    cmd.addr = a;
    @(negedge lclk);
    cmd.cs_n = 2'h3;
    {cmd.ras_n, cmd.cas_n, cmd.we_n} = 3'h7;
    @(posedge lclk);
  endtask

  task automatic write_burst(input logic [1:0] cs_n, input logic [2:0] ba, input logic [14:0] a,
                             input logic [63:0] d, input logic [7:0] m);
    busy = 1'b1;
    issue(cs_n, 3'h4, ba, a);
    repeat (3) @(negedge lclk);
    for (int b = 0; b < 4; b++) begin
      @(negedge lclk);
      din.dq         = d[16*b +: 16];
      din.write_mask = m[2*b +: 2];
      din.dqs        = 2'h2;
      din.dqs_c      = 2'h1;
    end
    @(posedge lclk);
    busy = 1'b0;
  endtask

  task automatic set_odt(input logic [1:0] v);
    @(negedge lclk);
    cmd.odt = v;
  endtask
endmodule

`default_nettype wire

// ---- tb/dual_rank_ddr3_access_path_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("BAD %0t %s", $time, msg); \
  end \
end

module dual_rank_ddr3_access_path_bench;
  import dr3_pkg::*;

  logic        clk_sys;
  logic        srst;
  logic        lclk;
  dr3_cfg_s    cfg;
  dr3_stat_s   status;
  dr3_cmd_s    cmd;
  dr3_din_s    din;
  dr3_dout_s   dout;
  int          mismatches;
  int          cmp_count;
  logic [39:0] expq[$];
  logic [7:0]  mem[int];
  logic        rk;
  logic        chop;
  logic [2:0]  ba;
  logic [14:0] row;
  logic [14:0] col;
  logic [39:0] e;

  dr3_dev dut (.clk_sys(clk_sys), .srst(srst), .cfg(cfg), .status(status),
               .cmd_clock_true(lclk), .cmd(cmd), .din(din), .dout(dout));
  dr3_ctrl_model u_ctrl (.lclk(lclk), .cmd(cmd), .din(din));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // link clock, phase unrelated to the system clock
  initial begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end

  // ======
  function automatic logic [2:0] pos(input logic [2:0] i);
    return cfg.interleave ? (col[2:0] ^ i) : {col[2] ^ i[2], col[1:0] + i[1:0]};
  endfunction

  function automatic int key(input logic [2:0] i);
    return int'({rk, ba, row[1:0], col[9:3], pos(i)});
  endfunction

  task automatic set_cfg(input logic w, input logic t, input dr3_bl_e bl, input logic il);
    @(negedge clk_sys);
    cfg = '{wide: w, term_en: t, burst_length: bl, interleave: il};
    repeat (4) @(negedge lclk);
  endtask

  task automatic do_write(input logic [63:0] d, input logic [7:0] m);
    for (int i = 0; i < (chop ? 4 : 8); i++) begin
      if (!m[i] || (cfg.wide && cfg.term_en)) mem[key(3'(i))] = d[8*i +: 8];
    end
    u_ctrl.write_burst({~rk, rk}, ba, col, d, m);
    @(negedge lclk);
    if (!chop) `CHK(status.wr_busy, 1'b1, "write capture busy")
    repeat (5) @(negedge lclk);
    `CHK(status.wr_busy, 1'b0, "write capture done")
  endtask

  task automatic do_read();
    for (int i = 0; i < (chop ? 4 : 8); i += 2) begin
      expq.push_back({cfg.wide ? 8'hff : 8'h0f, cfg.wide ? 16'hffff : 16'h0f0f,
                      mem[key(3'(i + 1))], mem[key(3'(i))]});
    end
    u_ctrl.issue({~rk, rk}, 3'h5, ba, col);
    repeat (3) @(negedge lclk);
    `CHK(status.rd_busy, 1'b1, "read busy")
    repeat (7) @(negedge lclk);
    `CHK(expq.size(), 0, "read beat count")
  endtask

  task automatic run_one();
    rk   = 1'($urandom);
    ba   = 3'($urandom);
    row  = 15'($urandom);
    col  = {2'h0, 1'($urandom), 2'h0, 10'($urandom)};
    chop = (cfg.burst_length == DR3_BC4) || (cfg.burst_length == DR3_OTF && !col[12]);
    u_ctrl.issue({~rk, rk}, 3'h3, ba, row);
    do_write({$urandom, $urandom}, 8'h00);
    `CHK(status.rank_open, {rk, ~rk}, "open rank")
    do_write({$urandom, $urandom}, 8'($urandom));
    do_read();
    u_ctrl.issue(2'h0, 3'h2, 3'h0, 15'h0400);
  endtask

  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ======
  // read beats are checked against the oldest note
  always @(negedge lclk) begin
    if (dout.dqs_oe === 1'b1) begin
      if (expq.size() == 0) `CHK(1'b1, 1'b0, "unexpected read beat")
      else begin
        e = expq.pop_front();
        `CHK(dout.dq & e[31:16], e[15:0] & e[31:16], "read data")
        `CHK(dout.dq_oe, e[39:32], "data drive enable")
        `CHK({dout.dqs, dout.dqs_c}, 4'h6, "read strobe")
      end
    end
  end

  initial begin
    #300_000;
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    cmp_count  = 0;
    srst       = 1'b1;
    cfg        = '{wide: 1'b1, term_en: 1'b0, burst_length: DR3_BL8, interleave: 1'b0};
    void'($urandom(59));
    repeat (10) @(negedge clk_sys);
    // the link side also needs four of its own edges in reset
    repeat (4) @(negedge lclk);
    @(negedge clk_sys);
    srst = 1'b0;
    repeat (6) @(negedge lclk);
    for (int m = 0; m < 3; m++) begin
      for (int il = 0; il < 2; il++) begin
        set_cfg(1'b1, 1'b0, dr3_bl_e'(m), il[0]);
        run_one();
      end
    end
    set_cfg(1'b0, 1'b1, DR3_BL8, 1'b0);
    u_ctrl.set_odt(2'h1);
    repeat (4) @(negedge lclk);
    `CHK({dout.term_strobe_true, dout.term_strobe_comp}, 2'h0, "spare balls idle")
    run_one();
    set_cfg(1'b1, 1'b1, DR3_BL8, 1'b1);
    `CHK({dout.term_strobe_true, dout.term_strobe_comp}, 2'h3, "termination strobe")
    run_one();
    `CHK(status.err, 1'b0, "no refusal yet")
    // deselected activate must leave the bank closed
    u_ctrl.issue(2'h3, 3'h3, 3'h0, 15'h0000);
    u_ctrl.issue(2'h2, 3'h5, 3'h0, 15'h0000);
    repeat (6) @(negedge lclk);
    `CHK(status.err, 1'b1, "read to closed bank")
    `CHK(status.rank_open, 2'h0, "deselected activate")
    // single-bank precharge leaves the other bank of the rank open
    u_ctrl.issue(2'h2, 3'h3, 3'h1, 15'h0000);
    u_ctrl.issue(2'h2, 3'h3, 3'h2, 15'h0000);
    u_ctrl.issue(2'h2, 3'h2, 3'h1, 15'h0000);
    repeat (4) @(negedge lclk);
    `CHK(status.rank_open, 2'h1, "single bank precharge")
    u_ctrl.issue(2'h2, 3'h2, 3'h2, 15'h0000);
    repeat (4) @(negedge lclk);
    `CHK(status.rank_open, 2'h0, "last bank precharge")
    `CHK(status.ovf, 1'b0, "write buffer overflow")
    test_done();
  end
endmodule

`default_nettype wire
